// [hdl/protect_defines.vh]
// Shared constants for the output protection logic
`ifndef PROTECT_DEFINES_VH
`define PROTECT_DEFINES_VH
`define LS_COUNT 8
`define HS_COUNT 4
`define FILTER_CYCLES 16'h0064
`define PEAK_CYCLES 16'h03E8
`define CNT_W 16
`define RST_LS 8'h00
`define RST_HS 4'h0
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define IRQ_W 4
`define IRQ_LS_FAULT 0
`define IRQ_HS_THERM 1
`define IRQ_UV 2
`define IRQ_GND 3
`define REG_CTRL_LS 4'h0
`define REG_CTRL_HS 4'h1
`define REG_SHUT_CFG 4'h2
`define REG_LIMIT_CFG 4'h3
`define REG_STATUS 4'h4
`define REG_IRQ_STAT 4'h5
`define REG_IRQ_MASK 4'h6
`define REG_OUT_STATE 4'h7
`endif

// [hdl/lowside_channel.v]
// One low-side channel: shutdown filter, latch and retry by command toggle
`timescale 1ns/1ps
`include "protect_defines.vh"
module lowside_channel #(
	parameter FILTER = `FILTER_CYCLES
) (
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	input wire soft_init,
	// Control
	input wire cmd_on,
	input wire shutdown_en,
	input wire overcurrent,
	input wire overtemp,
	input wire status_clear,
	// Result
	output reg drive_r,
	output reg fault_r,
	output reg latched_r,
	output reg fault_event_r
);
	reg [`CNT_W-1:0] cnt_r;
	reg cmd_d_r;
	wire rise = cmd_on & ~cmd_d_r;
	wire trip = shutdown_en & cmd_on & overcurrent & (cnt_r >= FILTER[`CNT_W-1:0]);
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= `CNT_ZERO;
			cmd_d_r <= 1'b0;
			drive_r <= 1'b0;
			fault_r <= 1'b0;
			latched_r <= 1'b0;
			fault_event_r <= 1'b0;
		end else if (soft_init) begin
			cnt_r <= `CNT_ZERO;
			cmd_d_r <= 1'b0;
			drive_r <= 1'b0;
			fault_r <= 1'b0;
			latched_r <= 1'b0;
			fault_event_r <= 1'b0;
		end else begin
			cmd_d_r <= cmd_on;
			fault_event_r <= trip & ~latched_r;
			if (shutdown_en & cmd_on & overcurrent & ~latched_r)
				cnt_r <= cnt_r + `CNT_ONE;
			else
				cnt_r <= `CNT_ZERO;
			if (trip)
				latched_r <= 1'b1;
			else if (rise)
				latched_r <= 1'b0;
			if (trip)
				fault_r <= 1'b1;
			else if (status_clear & ~latched_r & ~(cmd_on & overcurrent & shutdown_en))
				fault_r <= 1'b0;
			// Current-limit mode never latches; only overtemperature stops it
			drive_r <= cmd_on & ~latched_r & ~trip & ~(overtemp & ~shutdown_en);
		end
	end
endmodule

// [hdl/highside_channel.v]
// One high-side channel: peak then sustain limit, thermal auto-retry
`timescale 1ns/1ps
`include "protect_defines.vh"
module highside_channel #(
	parameter PEAK = `PEAK_CYCLES
) (
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	input wire soft_init,
	// Control
	input wire cmd_on,
	input wire sustain_only,
	input wire overtemp,
	// Result
	output reg drive_r,
	output reg peak_r,
	output reg therm_event_r
);
	reg [`CNT_W-1:0] cnt_r;
	reg ot_d_r;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= `CNT_ZERO;
			drive_r <= 1'b0;
			peak_r <= 1'b0;
			ot_d_r <= 1'b0;
			therm_event_r <= 1'b0;
		end else if (soft_init) begin
			cnt_r <= `CNT_ZERO;
			drive_r <= 1'b0;
			peak_r <= 1'b0;
			ot_d_r <= 1'b0;
			therm_event_r <= 1'b0;
		end else begin
			ot_d_r <= overtemp;
			therm_event_r <= cmd_on & overtemp & ~ot_d_r;
			drive_r <= cmd_on & ~overtemp;
			if (!cmd_on) begin
				cnt_r <= `CNT_ZERO;
				peak_r <= 1'b0;
			end else if (sustain_only) begin
				peak_r <= 1'b0;
			end else if (cnt_r < PEAK[`CNT_W-1:0]) begin
				cnt_r <= cnt_r + `CNT_ONE;
				peak_r <= 1'b1;
			end else begin
				peak_r <= 1'b0;
			end
		end
	end
endmodule

// [hdl/output_fault_protection_logic.v]
// Top of the output protection and fault sequencing logic
// Functional notes
// - Low-side config bit one selects overcurrent shutdown, zero selects current limit.
// - With shutdown disabled, no overcurrent fault is reported.
// - Commanded-on shutdown output with drain over threshold starts filter timer.
// - Filter expiry with overcurrent still present turns output off, latches fault.
// - Latched output re-enables only after commanded off then on again.
// - Cleared overcurrent on retry resumes output; status clears on chip-select rise.
// - Persisting overcurrent on retry latches off again, fault bit stays set.
// - Current-limit output keeps running, disabled only at overtemperature.
// - Overcurrent gone before thermal shutdown leaves nothing latched.
// - High-side limit bit zero: peak limit for timer interval, then sustain.
// - High-side limit bit one: sustain limit only from switch-on.
// - High-side thermal shutdown retries automatically until commanded off.
// - Ground loss forces all outputs off.
// - Below 6 V outputs off, logic kept above 5 V, restored after.
// - Below 5 V logic reinitializes to default state; the code keeps irq_mask_r and irq_stat_r.
// - Default state acts as all config zero; low sides follow direct input.
// - Low-side fault holds indicator low until output toggled or reset.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "protect_defines.vh"
module output_fault_protection_logic #(
	parameter FILTER = `FILTER_CYCLES,
	parameter PEAK = `PEAK_CYCLES
) (
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	// Register port
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_r,
	// Pins and analog monitors
	input wire cs_n,
	input wire lowside_direct_input,
	input wire [`HS_COUNT-1:0] highside_direct_input,
	input wire [`LS_COUNT-1:0] ls_overcurrent,
	input wire [`LS_COUNT-1:0] ls_overtemp,
	input wire [`HS_COUNT-1:0] hs_overtemp,
	input wire ground_lost,
	input wire below_6v,
	input wire below_5v,
	// Outputs
	output reg [`LS_COUNT-1:0] lowside_outputs,
	output reg [`HS_COUNT-1:0] highside_outputs,
	output reg [`HS_COUNT-1:0] peak_current_limit,
	output reg fault_indicator_pin_n,
	output reg irq_r
);
	// Two-flop synchronisers for all pins
	localparam SW = 5 + `LS_COUNT * 2 + `HS_COUNT * 2;
	// Chip select idles high: its flops reset high so no false rise follows reset
	localparam [SW-1:0] SYNC_IDLE = {1'b1, {(SW-1){1'b0}}};
	wire [SW-1:0] raw = {cs_n, lowside_direct_input, ground_lost, below_6v, below_5v,
		highside_direct_input, ls_overcurrent, ls_overtemp, hs_overtemp};
	reg [SW-1:0] s1_r;
	reg [SW-1:0] s2_r;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= SYNC_IDLE;
			s2_r <= SYNC_IDLE;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end
	wire [`HS_COUNT-1:0] hot_hs = s2_r[`HS_COUNT-1:0];
	wire [`LS_COUNT-1:0] hot_ls = s2_r[`HS_COUNT+`LS_COUNT-1:`HS_COUNT];
	wire [`LS_COUNT-1:0] oc_ls = s2_r[`HS_COUNT+2*`LS_COUNT-1:`HS_COUNT+`LS_COUNT];
	wire [`HS_COUNT-1:0] hs_in = s2_r[2*`HS_COUNT+2*`LS_COUNT-1:`HS_COUNT+2*`LS_COUNT];
	wire b5 = s2_r[SW-5];
	wire b6 = s2_r[SW-4];
	wire gnd = s2_r[SW-3];
	wire ls_in = s2_r[SW-2];
	wire cs_s = s2_r[SW-1];

	reg cs_d_r;
	reg b6_d_r;
	reg b5_d_r;
	wire cs_rise = cs_s & ~cs_d_r;
	// Reinit while below 5 V
	wire soft_init = b5;
	wire kill = gnd | b6;

	// Software registers
	reg [`LS_COUNT-1:0] ctrl_ls_r;
	reg [`HS_COUNT-1:0] ctrl_hs_r;
	reg [`LS_COUNT-1:0] shut_cfg_r;
	reg [`HS_COUNT-1:0] limit_cfg_r;
	reg [`LS_COUNT-1:0] ls_sel_r;
	reg [`HS_COUNT-1:0] hs_sel_r;
	reg [`IRQ_W-1:0] irq_stat_r;
	reg [`IRQ_W-1:0] irq_mask_r;

	wire [`LS_COUNT-1:0] ls_drive;
	wire [`LS_COUNT-1:0] ls_fault;
	wire [`LS_COUNT-1:0] ls_latched;
	wire [`LS_COUNT-1:0] ls_event;
	wire [`HS_COUNT-1:0] hs_drive;
	wire [`HS_COUNT-1:0] hs_peak;
	wire [`HS_COUNT-1:0] hs_event;

	// Command per output: register when selected, else direct input
	wire [`LS_COUNT-1:0] ls_cmd = (ls_sel_r & ctrl_ls_r) | (~ls_sel_r & {`LS_COUNT{ls_in}});
	wire [`HS_COUNT-1:0] hs_cmd = (hs_sel_r & ctrl_hs_r) | (~hs_sel_r & hs_in);

	genvar g;
	generate
		for (g = 0; g < `LS_COUNT; g = g + 1) begin : ls_ch
			lowside_channel #(.FILTER(FILTER)) u_ls (
				.mclk(mclk),
				.arst_n(arst_n),
				.soft_init(soft_init),
				.cmd_on(ls_cmd[g]),
				.shutdown_en(shut_cfg_r[g]),
				.overcurrent(oc_ls[g]),
				.overtemp(hot_ls[g]),
				.status_clear(cs_rise),
				.drive_r(ls_drive[g]),
				.fault_r(ls_fault[g]),
				.latched_r(ls_latched[g]),
				.fault_event_r(ls_event[g])
			);
		end
		for (g = 0; g < `HS_COUNT; g = g + 1) begin : hs_ch
			highside_channel #(.PEAK(PEAK)) u_hs (
				.mclk(mclk),
				.arst_n(arst_n),
				.soft_init(soft_init),
				.cmd_on(hs_cmd[g]),
				.sustain_only(limit_cfg_r[g]),
				.overtemp(hot_hs[g]),
				.drive_r(hs_drive[g]),
				.peak_r(hs_peak[g]),
				.therm_event_r(hs_event[g])
			);
		end
	endgenerate

	function hit;
		input [3:0] a;
		input [3:0] r;
		begin
			hit = (a == r);
		end
	endfunction

	wire [`IRQ_W-1:0] ev;
	assign ev[`IRQ_LS_FAULT] = |ls_event;
	assign ev[`IRQ_HS_THERM] = |hs_event;
	assign ev[`IRQ_UV] = b6 & ~b6_d_r;
	assign ev[`IRQ_GND] = gnd;

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cs_d_r <= 1'b1;
			b6_d_r <= 1'b0;
			b5_d_r <= 1'b0;
			ctrl_ls_r <= `RST_LS;
			ctrl_hs_r <= `RST_HS;
			shut_cfg_r <= `RST_LS;
			limit_cfg_r <= `RST_HS;
			ls_sel_r <= `RST_LS;
			hs_sel_r <= `RST_HS;
			irq_mask_r <= {`IRQ_W{1'b0}};
		end else begin
			cs_d_r <= cs_s;
			b6_d_r <= b6;
			b5_d_r <= b5;
			if (soft_init) begin
				ctrl_ls_r <= `RST_LS;
				ctrl_hs_r <= `RST_HS;
				shut_cfg_r <= `RST_LS;
				limit_cfg_r <= `RST_HS;
				ls_sel_r <= `RST_LS;
				hs_sel_r <= `RST_HS;
			end else if (reg_wr) begin
				// Writing control also loads the select bits from bits 8 and up; a one hands that output to register control
				if (hit(reg_addr, `REG_CTRL_LS)) begin
					ctrl_ls_r <= reg_wdata[`LS_COUNT-1:0];
					ls_sel_r <= reg_wdata[`LS_COUNT+7:8];
				end
				if (hit(reg_addr, `REG_CTRL_HS)) begin
					ctrl_hs_r <= reg_wdata[`HS_COUNT-1:0];
					hs_sel_r <= reg_wdata[`HS_COUNT+7:8];
				end
				if (hit(reg_addr, `REG_SHUT_CFG))
					shut_cfg_r <= reg_wdata[`LS_COUNT-1:0];
				if (hit(reg_addr, `REG_LIMIT_CFG))
					limit_cfg_r <= reg_wdata[`HS_COUNT-1:0];
				if (hit(reg_addr, `REG_IRQ_MASK))
					irq_mask_r <= reg_wdata[`IRQ_W-1:0];
			end
		end
	end

	// Sticky events: set wins over write-one-to-clear
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			irq_stat_r <= {`IRQ_W{1'b0}};
		else if (reg_wr & hit(reg_addr, `REG_IRQ_STAT))
			irq_stat_r <= (irq_stat_r & ~reg_wdata[`IRQ_W-1:0]) | ev;
		else
			irq_stat_r <= irq_stat_r | ev;
	end

	// Read data valid the cycle after the strobe
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`REG_CTRL_LS: reg_rdata_r <= {ls_sel_r, ctrl_ls_r};
				`REG_CTRL_HS: reg_rdata_r <= {4'h0, hs_sel_r, 4'h0, ctrl_hs_r};
				`REG_SHUT_CFG: reg_rdata_r <= {8'h00, shut_cfg_r};
				`REG_LIMIT_CFG: reg_rdata_r <= {12'h000, limit_cfg_r};
				`REG_STATUS: reg_rdata_r <= {ls_latched, ls_fault};
				`REG_IRQ_STAT: reg_rdata_r <= {12'h000, irq_stat_r};
				`REG_IRQ_MASK: reg_rdata_r <= {12'h000, irq_mask_r};
				`REG_OUT_STATE: reg_rdata_r <= {hs_peak, highside_outputs, lowside_outputs};
				default: reg_rdata_r <= 16'h0000;
			endcase
		end else begin
			reg_rdata_r <= 16'h0000;
		end
	end

	// Output stage
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lowside_outputs <= `RST_LS;
			highside_outputs <= `RST_HS;
			peak_current_limit <= `RST_HS;
			fault_indicator_pin_n <= 1'b1;
			irq_r <= 1'b0;
		end else begin
			lowside_outputs <= kill ? `RST_LS : ls_drive;
			highside_outputs <= kill ? `RST_HS : hs_drive;
			peak_current_limit <= kill ? `RST_HS : hs_peak;
			fault_indicator_pin_n <= ~(|ls_latched);
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end
endmodule

// [sim/protect_monitor.sv]
// Checker of the protection logic top ports
`timescale 1ns/1ps
module protect_monitor #(
	parameter PEAK = 16'h03E8
) (
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	// Inputs seen
	input wire reg_rd,
	input wire [7:0] ls_overcurrent,
	input wire [7:0] ls_overtemp,
	input wire [3:0] hs_overtemp,
	input wire ground_lost,
	input wire below_6v,
	input wire below_5v,
	// Outputs seen
	input wire [15:0] reg_rdata_r,
	input wire [7:0] lowside_outputs,
	input wire [3:0] highside_outputs,
	input wire [3:0] peak_current_limit,
	input wire fault_indicator_pin_n,
	input wire irq_r
);
	reg [15:0] pk_cnt_r;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// Cycles the peak limit has stood on output 0
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			pk_cnt_r <= 16'h0000;
		else
			pk_cnt_r <= peak_current_limit[0] ? pk_cnt_r + 16'h0001 : 16'h0000;
	end
	property p_gnd; ground_lost [*6] |-> {lowside_outputs, highside_outputs} == 12'h000; endproperty
	a_gnd: assert property (p_gnd) else $error("output on after ground loss");
	property p_uv6; below_6v [*6] |-> {lowside_outputs, highside_outputs} == 12'h000; endproperty
	a_uv6: assert property (p_uv6) else $error("output on below 6 V");
	property p_uv5; below_5v [*6] |-> ~|{lowside_outputs, highside_outputs}; endproperty
	a_uv5: assert property (p_uv5) else $error("output on below 5 V");
	property p_trip; $fell(fault_indicator_pin_n) |-> |$past(ls_overcurrent, 4); endproperty
	a_trip: assert property (p_trip) else $error("fault pin low without overcurrent");
	property p_rd; !$past(reg_rd) |-> reg_rdata_r == 16'h0000; endproperty
	a_rd: assert property (p_rd) else $error("read data outside its cycle");
	property p_pk; pk_cnt_r <= PEAK + 2; endproperty
	a_pk: assert property (p_pk) else $error("peak limit held too long");
	property p_hot; hs_overtemp[0] [*6] |-> !highside_outputs[0]; endproperty
	a_hot: assert property (p_hot) else $error("high side on while hot");
	property p_lot; ls_overtemp[1] [*6] |-> !lowside_outputs[1]; endproperty
	a_lot: assert property (p_lot) else $error("low side on while hot");
	c_trip: cover property ($fell(fault_indicator_pin_n));
	c_peak: cover property ($fell(peak_current_limit[0]));
	c_irq: cover property ($rose(irq_r));
endmodule
bind output_fault_protection_logic protect_monitor #(.PEAK(PEAK)) u_mon (.mclk(mclk),
	.arst_n(arst_n), .reg_rd(reg_rd), .ls_overcurrent(ls_overcurrent), .ls_overtemp(ls_overtemp),
	.hs_overtemp(hs_overtemp), .ground_lost(ground_lost), .below_6v(below_6v),
	.below_5v(below_5v), .reg_rdata_r(reg_rdata_r), .lowside_outputs(lowside_outputs),
	.highside_outputs(highside_outputs), .peak_current_limit(peak_current_limit),
	.fault_indicator_pin_n(fault_indicator_pin_n), .irq_r(irq_r));

// [sim/host_model.sv]
// Host model: master of the register port
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire mclk,
	// Register port
	output reg [3:0] reg_addr = 4'h0,
	output reg [15:0] reg_wdata = 16'h0000,
	output reg reg_wr = 1'b0,
	output reg reg_rd = 1'b0,
	input wire [15:0] reg_rdata_r
);
	task wr(input [3:0] a, input [15:0] d);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge mclk);
			reg_wr <= 1'b0;
		end
	endtask
	// Read data stands only in the cycle after the strobe
	task rd(input [3:0] a, output [15:0] d);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1;
			d = reg_rdata_r;
		end
	endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench for the output protection logic
`timescale 1ns/1ps
module testbench;
	localparam PEAK = 16'h0004;
	reg mclk = 1'b0;
	reg arst_n = 1'b0;
	reg cs_n = 1'b1;
	reg lsi = 1'b0;
	reg [3:0] hsi = 4'h0;
	reg [7:0] oc = 8'h00;
	reg [7:0] lot = 8'h00;
	reg [3:0] hot = 4'h0;
	reg gnd = 1'b0;
	reg uv6 = 1'b0;
	reg uv5 = 1'b0;
	wire [3:0] addr;
	wire [15:0] wdata;
	wire wr;
	wire rd;
	wire [15:0] rdata;
	wire [7:0] ls;
	wire [3:0] hs;
	wire [3:0] pk;
	wire fault_n;
	wire irq;
	reg [15:0] v;
	integer bad_count = 0;
	integer compares = 0;
	integer i;
	always #5 mclk = ~mclk;
	host_model u_host (.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata_r(rdata));
	output_fault_protection_logic #(.FILTER(16'h0004), .PEAK(PEAK)) u_dut (.mclk(mclk),
		.arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata_r(rdata), .cs_n(cs_n), .lowside_direct_input(lsi),
		.highside_direct_input(hsi), .ls_overcurrent(oc), .ls_overtemp(lot), .hs_overtemp(hot),
		.ground_lost(gnd), .below_6v(uv6), .below_5v(uv5), .lowside_outputs(ls),
		.highside_outputs(hs), .peak_current_limit(pk), .fault_indicator_pin_n(fault_n),
		.irq_r(irq));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task settle;
		begin
			repeat (16) @(posedge mclk);
			#1;
		end
	endtask
	task end_of_test;
		begin
			$display("compares %0d mismatches %0d", compares, bad_count);
			if (bad_count == 0 && compares > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task t_hs(input [15:0] cfg, input exp_pk);
		begin
			u_host.wr(4'h3, cfg);
			@(posedge mclk) hsi <= 4'h1;
			for (i = 0; i < 20 && hs[0] !== 1'b1; i = i + 1)
				@(posedge mclk);
			#1;
			chk({14'h0000, hs[0], pk[0]}, {14'h0000, 1'b1, exp_pk});
			repeat (PEAK + 2) @(posedge mclk);
			#1;
			chk({14'h0000, hs[0], pk[0]}, 16'h0002);
			@(posedge mclk) hsi <= 4'h0;
			settle;
		end
	endtask
	task t_hot;
		begin
			@(posedge mclk) hsi <= 4'h1;
			repeat (2) begin
				@(posedge mclk) hot <= 4'h1;
				settle;
				chk({12'h000, hs}, 16'h0000);
				@(posedge mclk) hot <= 4'h0;
				settle;
				chk({12'h000, hs}, 16'h0001);
			end
			@(posedge mclk) hsi <= 4'h0;
		end
	endtask
	task t_shut;
		begin
			u_host.wr(4'h2, 16'h0001);
			@(posedge mclk) lsi <= 1'b1;
			settle;
			@(posedge mclk) oc <= 8'h03;
			settle;
			chk({6'h00, fault_n, irq, ls}, 16'h00fe);
			u_host.wr(4'h6, 16'h0001);
			settle;
			chk({15'h0000, irq}, 16'h0001);
			u_host.rd(4'h4, v);
			chk(v, 16'h0101);
			@(posedge mclk) lsi <= 1'b0;
			settle;
			@(posedge mclk) lsi <= 1'b1;
			settle;
			u_host.rd(4'h4, v);
			chk({ls, v[15:8]}, 16'hfe01);
			@(posedge mclk) oc <= 8'h00;
			@(posedge mclk) lsi <= 1'b0;
			settle;
			@(posedge mclk) lsi <= 1'b1;
			settle;
			u_host.rd(4'h4, v);
			chk({7'h00, fault_n, ls}, 16'h01ff);
			chk(v, 16'h0001);
			@(posedge mclk) cs_n <= 1'b0;
			settle;
			@(posedge mclk) cs_n <= 1'b1;
			settle;
			u_host.rd(4'h4, v);
			chk(v, 16'h0000);
			u_host.wr(4'h5, 16'h0001);
			settle;
			chk({15'h0000, irq}, 16'h0000);
		end
	endtask
	task t_limit;
		begin
			@(posedge mclk) oc <= 8'h02;
			settle;
			u_host.rd(4'h4, v);
			chk({ls, v[7:0]}, 16'hff00);
			@(posedge mclk) lot <= 8'h02;
			settle;
			chk({8'h00, ls}, 16'h00fd);
			@(posedge mclk);
			lot <= 8'h00;
			oc <= 8'h00;
			settle;
			chk({8'h00, ls}, 16'h00ff);
		end
	endtask
	task t_supply;
		begin
			@(posedge mclk) hsi <= 4'h3;
			for (i = 0; i < 3; i = i + 1) begin
				@(posedge mclk);
				gnd <= (i == 0);
				uv6 <= (i != 0);
				uv5 <= (i == 2);
				settle;
				chk({4'h0, ls, hs}, 16'h0000);
				@(posedge mclk);
				gnd <= 1'b0;
				uv6 <= 1'b0;
				uv5 <= 1'b0;
				settle;
				chk({4'h0, ls, hs}, 16'h0ff3);
				u_host.rd(4'h2, v);
				chk(v, (i == 2) ? 16'h0000 : 16'h0001);
			end
		end
	endtask
	// Register control of outputs, serial retry, event status readback
	task t_reg;
		begin
			u_host.rd(4'h5, v);
			chk(v, 16'h000e);
			u_host.wr(4'h5, 16'h000f);
			u_host.rd(4'h5, v);
			chk(v, 16'h0000);
			u_host.wr(4'h0, 16'hff0f);
			settle;
			chk({8'h00, ls}, 16'h000f);
			u_host.rd(4'h7, v);
			chk(v, 16'h030f);
			u_host.rd(4'h0, v);
			chk(v, 16'hff0f);
			u_host.wr(4'h2, 16'h0001);
			@(posedge mclk) oc <= 8'h01;
			settle;
			chk({7'h00, fault_n, ls}, 16'h000e);
			@(posedge mclk) oc <= 8'h00;
			settle;
			chk({7'h00, fault_n, ls}, 16'h000e);
			u_host.wr(4'h0, 16'hff0e);
			u_host.wr(4'h0, 16'hff0f);
			settle;
			chk({7'h00, fault_n, ls}, 16'h010f);
			u_host.wr(4'h1, 16'h0f05);
			settle;
			chk({12'h000, hs}, 16'h0005);
			u_host.rd(4'h1, v);
			chk(v, 16'h0f05);
		end
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		#1;
		chk({3'h0, fault_n, ls, hs}, 16'h1000);
		u_host.rd(4'h9, v);
		chk(v, 16'h0000);
		t_hs(16'h0000, 1'b1);
		t_hs(16'h0001, 1'b0);
		t_hot;
		t_shut;
		t_limit;
		t_supply;
		t_reg;
		end_of_test;
	end
	initial begin
		#200000;
		bad_count = bad_count + 1;
		end_of_test;
	end
endmodule
